// file: inc/iefs_pkg.sv
// shared constants and carrier types for the i/o extension fail-safe controller
package iefs_pkg;

  // clock and timing
  localparam longint CLK_HZ         = 250_000_000;
  localparam longint SLOW_FLASH_MHZ = 1400;   // slow error flash, milli-hertz
  localparam longint FAST_FLASH_MHZ = 2800;   // fast error flash, milli-hertz
  localparam longint REG_TIMEOUT_MS = 1000;   // register traffic watchdog, ms
  localparam int unsigned SLOW_HALF_CYC = int'(CLK_HZ * 1000 / (2 * SLOW_FLASH_MHZ));
  localparam int unsigned FAST_HALF_CYC = int'(CLK_HZ * 1000 / (2 * FAST_FLASH_MHZ));
  localparam int unsigned REG_TIMEOUT_CYC = int'(CLK_HZ / 1000 * REG_TIMEOUT_MS);
  localparam int CNT_W = 28;

  // register numbers: input window 30xx0, holding window 40xx0
  localparam logic [15:0] IN_REG_BASE   = 16'h7530;  // 30000
  localparam logic [15:0] HOLD_REG_BASE = 16'h9c40;  // 40000
  localparam int          WORDS         = 3;
  localparam logic [1:0]  LAST_WORD     = 2'h2;

  // function codes
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_MULT = 8'h10;

  // thumbwheel digit codes
  localparam logic [3:0] DIGIT_MAX  = 4'h9;
  localparam logic [3:0] DIGIT_STAR = 4'ha;

  // switch positions
  localparam int SW_AI_RANGE = 0;
  localparam int SW_AO_HOLD  = 1;
  localparam int SW_RLY1_HOLD = 2;
  localparam int SW_RLY2_HOLD = 3;

  // live-zero offset: 4 mA of a 0..20 mA full scale
  localparam logic [15:0] LIVE_ZERO_OFS = 16'h3333;

  // reset values
  localparam logic [15:0] WORD_RST = 16'h0000;

  // status word bit positions (input word 2)
  localparam int ST_FAULT     = 0;
  localparam int ST_LIVE_ZERO = 1;
  localparam int ST_UNDERRANGE = 2;
  localparam int ST_ADDR_CHG  = 3;

  typedef enum logic [1:0] {
    IEFS_AD_FACTORY,
    IEFS_AD_MAP,
    IEFS_AD_SLAVE,
    IEFS_AD_ILLEGAL
  } iefs_addr_kind_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [7:0]  fc;
    logic        wr;
    logic        rd;
  } iefs_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        ok;
  } iefs_rsp_t;

endpackage

// file: src/iefs_ctrl.sv
// fail-safe, indicator, address and register logic of the six-channel i/o extension
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps

module iefs_ctrl #(
  parameter int unsigned SLOW_HALF   = iefs_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF   = iefs_pkg::FAST_HALF_CYC,
  parameter int unsigned REG_TIMEOUT = iefs_pkg::REG_TIMEOUT_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [3:0]         dip_switch_i,
  input  wire logic [7:0]         thumbwheel_i,
  input  wire logic [1:0]         digital_in_i,
  input  wire logic               link_up_i,
  input  wire logic               register_mode_i,
  input  wire logic               config_mode_i,
  input  wire logic               partner_ok_i,
  input  wire logic               critical_error_i,
  input  wire logic [15:0]        adc_code_i,
  input  wire iefs_pkg::iefs_req_t req_i,
  output logic                    [15:0] analog_out_o,
  output logic                    [1:0]  relay_out_o,
  output logic                    [1:0]  digital_in_led_o,
  output logic                    [1:0]  relay_led_o,
  output logic                    bus_activity_indicator_o,
  output logic                    error_indicator_o,
  output logic                    supply_indicator_o,
  output logic                    live_zero_o,
  output logic                    fault_o,
  output logic                    map_addr_valid_o,
  output logic                    slave_mode_o,
  output logic [3:0]              slave_addr_o,
  output iefs_pkg::iefs_rsp_t     rsp_o
);
  import iefs_pkg::*;
  localparam int PIN_W = 15;
  // pin synchronisers: three stages, a change is taken when stages two and three agree
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q  <= '0;
    end else begin
      pin_s1 <= {link_up_i, digital_in_i, thumbwheel_i, dip_switch_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // continuous switch sampling: agreed changes act at once, no restart needed
      for (int i = 0; i < PIN_W; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end
  logic [3:0] sw;
  logic [3:0] wheel_lo;
  logic [3:0] wheel_hi;
  logic [1:0] di;
  logic       link_ok;
  assign sw       = pin_q[3:0];
  assign wheel_lo = pin_q[7:4];
  assign wheel_hi = pin_q[11:8];
  assign di       = pin_q[13:12];
  assign link_ok  = pin_q[14];
  // address classification
  // a star in the units position or a non-digit code other than a tens-position star is never accepted
  iefs_addr_kind_t addr_kind;
  always_comb begin
    if (wheel_hi > DIGIT_MAX || wheel_lo > DIGIT_MAX) begin
      addr_kind = (wheel_hi == DIGIT_STAR && wheel_lo != 4'h0 && wheel_lo <= DIGIT_MAX) ?
                  IEFS_AD_SLAVE : IEFS_AD_ILLEGAL;
    end else if (wheel_hi == 4'h0 && wheel_lo == 4'h0) begin
      addr_kind = IEFS_AD_FACTORY;
    end else begin
      addr_kind = IEFS_AD_MAP;
    end
  end
  // window base is ten times the two-digit address
  logic [15:0] win_base;
  assign win_base = (16'(wheel_hi) * 16'd100) + (16'(wheel_lo) * 16'd10);
  // address change: the wheel is caught once the filter has flushed, then compared
  logic [4:0] boot_fill;
  logic [7:0] boot_wheel;
  logic       addr_changed;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_fill    <= '0;
      boot_wheel   <= 8'h00;
      addr_changed <= 1'b0;
    end else if (!boot_fill[4]) begin
      // filter stages hold reset zeros for four edges, so keep re-taking the wheel
      boot_fill  <= {boot_fill[3:0], 1'b1};
      boot_wheel <= {wheel_hi, wheel_lo};
    end else if ({wheel_hi, wheel_lo} != boot_wheel) begin
      addr_changed <= 1'b1;  // sticky until restart; the new address is decoded at once
    end
  end
  // register access decode
  logic        in_hit;
  logic        hold_hit;
  logic [1:0]  word_sel;
  logic [15:0] in_ofs;
  logic [15:0] hold_ofs;
  always_comb begin
    in_ofs   = req_i.addr - IN_REG_BASE - win_base;
    hold_ofs = req_i.addr - HOLD_REG_BASE - win_base;
    in_hit   = (addr_kind == IEFS_AD_MAP) && (in_ofs <= 16'(LAST_WORD)) &&
               (req_i.addr >= IN_REG_BASE);
    hold_hit = (addr_kind == IEFS_AD_MAP) && (hold_ofs <= 16'(LAST_WORD)) &&
               (req_i.addr >= HOLD_REG_BASE);
    word_sel = in_hit ? in_ofs[1:0] : hold_ofs[1:0];
  end
  // three output words written by the host
  logic [15:0] out_word [WORDS];
  logic        wr_ok;
  // write multiple code stores one word per strobe
  assign wr_ok = req_i.wr && hold_hit && req_i.fc == FC_WRITE_MULT;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        out_word[i] <= WORD_RST;
      end
    end else if (wr_ok) begin
      out_word[word_sel] <= req_i.wdata;
    end
  end
  // register traffic watchdog; counts only in register mode
  logic [CNT_W-1:0] wd_cnt;
  logic             reg_timeout;
  logic             any_ok;
  assign any_ok = wr_ok ||
                  (req_i.rd && in_hit && req_i.fc == FC_READ_INPUT) ||
                  (req_i.rd && hold_hit && req_i.fc == FC_READ_HOLD);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt      <= '0;
      reg_timeout <= 1'b0;
    end else if (!register_mode_i || any_ok) begin
      wd_cnt      <= '0;
      reg_timeout <= 1'b0;
    end else if (wd_cnt >= CNT_W'(REG_TIMEOUT - 1)) begin
      reg_timeout <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end
  // error sources that force the safe outputs
  logic fault;
  assign fault = !link_ok || critical_error_i || (register_mode_i && reg_timeout) ||
                 (!register_mode_i && !partner_ok_i);
  // last valid outputs, frozen while the fault lasts
  logic [15:0] ao_last;
  logic [1:0]  rly_last;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ao_last  <= WORD_RST;
      rly_last <= 2'h0;
    end else if (!fault) begin
      ao_last  <= out_word[0];
      rly_last <= out_word[1][1:0];
    end
  end
  // output drive with the switch-selected fail-safe policy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_out_o <= WORD_RST;
      relay_out_o  <= 2'h0;
      fault_o      <= 1'b0;
    end else begin
      fault_o <= fault;
      if (fault) begin
        analog_out_o <= sw[SW_AO_HOLD] ? ao_last : WORD_RST;
        relay_out_o[0] <= sw[SW_RLY1_HOLD] & rly_last[0];
        relay_out_o[1] <= sw[SW_RLY2_HOLD] & rly_last[1];
      end else begin
        analog_out_o <= out_word[0];
        relay_out_o  <= out_word[1][1:0];
      end
    end
  end
  // live-zero range removes the 4 mA offset; below it the reading clamps
  logic [15:0] ai_value;
  logic        ai_under;
  always_comb begin
    ai_under = sw[SW_AI_RANGE] && (adc_code_i < LIVE_ZERO_OFS);
    if (!sw[SW_AI_RANGE]) begin
      ai_value = adc_code_i;
    end else if (ai_under) begin
      ai_value = WORD_RST;
    end else begin
      ai_value = adc_code_i - LIVE_ZERO_OFS;
    end
  end
  // input image: analog value, digital inputs, status
  logic [15:0] in_word [WORDS];
  always_comb begin
    in_word[0] = ai_value;
    in_word[1] = {14'h0000, di};
    in_word[2] = '0;
    in_word[2][ST_FAULT]      = fault;
    in_word[2][ST_LIVE_ZERO]  = sw[SW_AI_RANGE];
    in_word[2][ST_UNDERRANGE] = ai_under;
    in_word[2][ST_ADDR_CHG]   = addr_changed;
  end
  // read answer one cycle after the strobe; unmapped or wrong code gives ok low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else if (req_i.rd) begin
      if (in_hit && req_i.fc == FC_READ_INPUT) begin
        rsp_o <= '{rdata: in_word[word_sel], ok: 1'b1};
      end else if (hold_hit && req_i.fc == FC_READ_HOLD) begin
        // holding read returns stored output words
        rsp_o <= '{rdata: out_word[word_sel], ok: 1'b1};
      end else begin
        rsp_o <= '0;
      end
    end else begin
      rsp_o <= '0;
    end
  end
  // free-running flash phases; fast drives both indicators, slow only the error indicator
  logic [CNT_W-1:0] slow_cnt;
  logic [CNT_W-1:0] fast_cnt;
  logic             slow_ph;
  logic             fast_ph;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slow_cnt <= '0;
      fast_cnt <= '0;
      slow_ph  <= 1'b0;
      fast_ph  <= 1'b0;
    end else begin
      if (slow_cnt >= CNT_W'(SLOW_HALF - 1)) begin
        slow_cnt <= '0;
        slow_ph  <= !slow_ph;
      end else begin
        slow_cnt <= slow_cnt + 1'b1;
      end
      if (fast_cnt >= CNT_W'(FAST_HALF - 1)) begin
        fast_cnt <= '0;
        fast_ph  <= !fast_ph;
      end else begin
        fast_cnt <= fast_cnt + 1'b1;
      end
    end
  end
  typedef enum logic [1:0] {IEFS_BUS_NONE, IEFS_BUS_CONFIG, IEFS_BUS_CYCLIC} iefs_bus_st_t;
  iefs_bus_st_t bus_st;
  always_comb begin
    if (!link_ok || (register_mode_i && reg_timeout)) begin
      bus_st = IEFS_BUS_NONE;
    end else if (config_mode_i) begin
      bus_st = IEFS_BUS_CONFIG;
    end else begin
      bus_st = IEFS_BUS_CYCLIC;
    end
  end
  // indicator drive; error priority: steady, fast, slow, dark
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_activity_indicator_o <= 1'b0;
      error_indicator_o        <= 1'b0;
      supply_indicator_o       <= 1'b0;
      digital_in_led_o         <= 2'h0;
      relay_led_o              <= 2'h0;
    end else begin
      supply_indicator_o <= 1'b1;
      unique case (bus_st)
        IEFS_BUS_NONE:   bus_activity_indicator_o <= 1'b0;
        IEFS_BUS_CONFIG: bus_activity_indicator_o <= fast_ph;
        IEFS_BUS_CYCLIC: bus_activity_indicator_o <= 1'b1;
      endcase
      if (critical_error_i || (register_mode_i && reg_timeout)) begin
        error_indicator_o <= 1'b1;
      // fast flash in i/o data mode
      end else if (!register_mode_i && (!partner_ok_i || !link_ok)) begin
        error_indicator_o <= fast_ph;
      end else if (addr_changed) begin
        error_indicator_o <= slow_ph;
      end else begin
        error_indicator_o <= 1'b0;
      end
      digital_in_led_o <= di;
      relay_led_o      <= relay_out_o;
    end
  end
  // address report outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_zero_o      <= 1'b0;
      map_addr_valid_o <= 1'b0;
      slave_mode_o     <= 1'b0;
      slave_addr_o     <= 4'h0;
    end else begin
      live_zero_o      <= sw[SW_AI_RANGE];
      map_addr_valid_o <= addr_kind == IEFS_AD_MAP;
      slave_mode_o     <= addr_kind == IEFS_AD_SLAVE;
      slave_addr_o     <= (addr_kind == IEFS_AD_SLAVE) ? wheel_lo : 4'h0;
    end
  end
endmodule

// file: tb/iefs_ctrl_chk.sv
// port-level assertions for the fail-safe controller
`timescale 1ns/10ps
module iefs_ctrl_chk (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic [3:0]          dip_switch_i,
  input wire logic [7:0]          thumbwheel_i,
  input wire logic                link_up_i,
  input wire logic                critical_error_i,
  input wire iefs_pkg::iefs_req_t req_i,
  input wire logic [15:0]         analog_out_o,
  input wire logic [1:0]          relay_out_o,
  input wire logic                bus_activity_indicator_o,
  input wire logic                error_indicator_o,
  input wire logic                live_zero_o,
  input wire logic                fault_o,
  input wire logic                map_addr_valid_o,
  input wire logic                slave_mode_o,
  input wire logic [3:0]          slave_addr_o,
  input wire iefs_pkg::iefs_rsp_t rsp_o
);
  import iefs_pkg::*;
  logic [15:0] ofs;
  logic        in_win;
  logic        hold_win;
  logic        map_pat;
  logic        sl_pat;
  // window offset taken from the wheel pins, so reads must follow a settled wheel
  assign ofs      = 16'(10 * (10 * thumbwheel_i[7:4] + thumbwheel_i[3:0]));
  assign in_win   = (req_i.addr - IN_REG_BASE - ofs) < 16'h3;
  assign hold_win = (req_i.addr - HOLD_REG_BASE - ofs) < 16'h3;
  assign map_pat  = thumbwheel_i[7:4] <= DIGIT_MAX && thumbwheel_i[3:0] <= DIGIT_MAX
                    && |thumbwheel_i;
  assign sl_pat   = thumbwheel_i[7:4] == DIGIT_STAR && thumbwheel_i[3:0] != 4'h0
                    && thumbwheel_i[3:0] <= DIGIT_MAX;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // six samples cover the three-stage pin filter plus the output register; the map
  // check needs seven, as an attempt opened on the release edge is not disabled
  a_read_ok: assert property (
    req_i.rd && req_i.fc == FC_READ_INPUT && in_win && map_addr_valid_o |=> rsp_o.ok)
    else $error("input read not answered");
  a_refuse_win: assert property (
    req_i.rd && !in_win && !hold_win |=> !rsp_o.ok) else $error("foreign read answered");
  a_idle_rsp: assert property (
    !req_i.rd |=> !rsp_o.ok && rsp_o.rdata == 16'h0) else $error("answer without read");
  a_live_zero: assert property (
    $stable(dip_switch_i[0]) [*6] |-> live_zero_o == dip_switch_i[0])
    else $error("range select not applied");
  a_ao_reset: assert property (
    (fault_o && !dip_switch_i[1]) [*6] |-> analog_out_o == 16'h0)
    else $error("analog out not zeroed");
  a_relay_drop: assert property (
    (fault_o && !dip_switch_i[2]) [*6] |-> !relay_out_o[0]) else $error("relay one held");
  a_bus_dark: assert property (
    !link_up_i [*6] |-> !bus_activity_indicator_o) else $error("bus lamp lit without link");
  a_err_steady: assert property (
    critical_error_i [*3] |-> error_indicator_o) else $error("error lamp not steady");
  a_map_valid: assert property (
    $stable(thumbwheel_i) [*7] |-> map_addr_valid_o == map_pat)
    else $error("map address decode wrong");
  a_slave_addr: assert property (
    $stable(thumbwheel_i) [*6] |-> slave_mode_o == sl_pat
      && slave_addr_o == (sl_pat ? thumbwheel_i[3:0] : 4'h0))
    else $error("slave address decode wrong");
  c_read: cover property (rsp_o.ok);
  c_fault: cover property (fault_o);
  c_slave: cover property (slave_mode_o);
  c_flash: cover property ($rose(error_indicator_o) ##4 $fell(error_indicator_o));
endmodule

bind iefs_ctrl iefs_ctrl_chk u_chk (.*);

// file: tb/iefs_ctrl_test.sv
// self-checking bench for the fail-safe controller
`timescale 1ns/10ps
module iefs_ctrl_test;
  import iefs_pkg::*;
  localparam int SH = 8;
  localparam int FH = 4;
  localparam int TO = 40;
  localparam logic [15:0] IB = IN_REG_BASE + 16'h78;
  localparam logic [15:0] HB = HOLD_REG_BASE + 16'h78;
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  dip_switch_i;
  logic [7:0]  thumbwheel_i;
  logic [1:0]  digital_in_i;
  logic        link_up_i;
  logic        register_mode_i;
  logic        config_mode_i;
  logic        partner_ok_i;
  logic        critical_error_i;
  logic [15:0] adc_code_i;
  iefs_req_t   req_i;
  logic [15:0] analog_out_o;
  logic [1:0]  relay_out_o;
  logic [1:0]  digital_in_led_o;
  logic [1:0]  relay_led_o;
  logic        bus_activity_indicator_o;
  logic        error_indicator_o;
  logic        supply_indicator_o;
  logic        live_zero_o;
  logic        fault_o;
  logic        map_addr_valid_o;
  logic        slave_mode_o;
  logic [3:0]  slave_addr_o;
  iefs_rsp_t   rsp_o;
  iefs_rsp_t   r;
  int          n;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // short flash and watchdog counts keep the run brief
  iefs_ctrl #(.SLOW_HALF(SH), .FAST_HALF(FH), .REG_TIMEOUT(TO)) uut (.*);
  iefs_host host (
    .clk_i          (clk_i),
    .rsp_i          (rsp_o),
    .req_o          (req_i),
    .link_up_o      (link_up_i),
    .register_mode_o(register_mode_i),
    .config_mode_o  (config_mode_i),
    .partner_ok_o   (partner_ok_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // hang guard: the scenarios need well under a thousand cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end
  task chk(input logic [16:0] s, input logic [16:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %0t: got %h want %h", $time, s, e);
    end
  endtask
  task w(input int c);
    repeat (c) @(negedge clk_i);
  endtask
  function automatic logic sig(input logic e);
    return e ? error_indicator_o : bus_activity_indicator_o;
  endfunction
  // the first level after a mode change may be clipped, so time the third
  task automatic half(input logic e, output int c);
    logic v;
    for (int k = 0; k < 3; k++) begin
      v = sig(e);
      c = 0;
      while (sig(e) === v && c < 100) begin
        @(negedge clk_i);
        c++;
      end
    end
  endtask
  task t_regs();
    host.wr(HB, FC_WRITE_MULT, 16'h1234);
    host.wr(HB + 16'h1, FC_WRITE_MULT, 16'h0003);
    host.wr(HB + 16'h2, FC_WRITE_MULT, 16'habcd);
    host.wr(HB + 16'h2, FC_READ_HOLD, 16'h5555);
    host.rd(HB + 16'h2, FC_READ_HOLD, r);
    chk(r, {16'habcd, 1'b1});
    chk(analog_out_o, 16'h1234);
    chk(relay_out_o, 2'h3);
    chk(relay_led_o, 2'h3);
    host.rd(HB + 16'h3, FC_READ_HOLD, r);
    chk(r, 17'h0);
    host.rd(IB + 16'ha, FC_READ_INPUT, r);
    chk(r, 17'h0);
    host.rd(IB, FC_READ_HOLD, r);
    chk(r, 17'h0);
  endtask
  task t_inputs();
    @(posedge clk_i);
    dip_switch_i <= 4'h1;
    adc_code_i <= 16'h5000;
    digital_in_i <= 2'h2;
    w(8);
    chk(live_zero_o, 1'b1);
    chk(digital_in_led_o, 2'h2);
    host.rd(IB, FC_READ_INPUT, r);
    chk(r, {16'h1ccd, 1'b1});
    host.rd(IB + 16'h1, FC_READ_INPUT, r);
    chk(r, {16'h0002, 1'b1});
    @(posedge clk_i);
    adc_code_i <= 16'h1000;
    w(2);
    host.rd(IB, FC_READ_INPUT, r);
    chk(r, {16'h0000, 1'b1});
    host.rd(IB + 16'h2, FC_READ_INPUT, r);
    chk(r, {16'h0006, 1'b1});
    @(posedge clk_i);
    dip_switch_i <= 4'ha;
    w(8);
    host.rd(IB, FC_READ_INPUT, r);
    chk(r, {16'h1000, 1'b1});
  endtask
  task t_fault();
    @(posedge clk_i);
    host.link_up_o <= 1'b0;
    w(12);
    chk(fault_o, 1'b1);
    chk(analog_out_o, 16'h1234);
    chk(relay_out_o, 2'h2);
    chk(bus_activity_indicator_o, 1'b0);
    @(posedge clk_i);
    dip_switch_i <= 4'hc;
    w(8);
    chk(analog_out_o, 16'h0);
    chk(relay_out_o, 2'h3);
    @(posedge clk_i);
    host.link_up_o <= 1'b1;
    w(8);
    chk(fault_o, 1'b0);
    chk(analog_out_o, 16'h1234);
  endtask
  task t_leds();
    chk(bus_activity_indicator_o, 1'b1);
    @(posedge clk_i);
    host.config_mode_o <= 1'b1;
    half(1'b0, n);
    chk(17'(n), 17'(FH));
    @(posedge clk_i);
    host.config_mode_o <= 1'b0;
    host.partner_ok_o <= 1'b0;
    half(1'b1, n);
    chk(17'(n), 17'(FH));
    @(posedge clk_i);
    host.partner_ok_o <= 1'b1;
    critical_error_i <= 1'b1;
    w(4);
    chk(error_indicator_o, 1'b1);
    @(posedge clk_i);
    critical_error_i <= 1'b0;
    host.register_mode_o <= 1'b1;
    w(TO + 6);
    chk(error_indicator_o, 1'b1);
    chk(fault_o, 1'b1);
    host.wr(HB + 16'h2, FC_WRITE_MULT, 16'h0000);
    w(4);
    chk(fault_o, 1'b0);
    chk(error_indicator_o, 1'b0);
    @(posedge clk_i);
    host.register_mode_o <= 1'b0;
  endtask
  task t_wheel();
    logic [7:0] wh [5] = '{8'h00, 8'ha3, 8'h3a, 8'haa, 8'h99};
    logic [5:0] ex [5] = '{6'h00, 6'h13, 6'h00, 6'h00, 6'h20};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      thumbwheel_i <= wh[i];
      w(8);
      chk({map_addr_valid_o, slave_mode_o, slave_addr_o}, ex[i]);
    end
    half(1'b1, n);
    chk(17'(n), 17'(SH));
  endtask
  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    dip_switch_i = 4'h0;
    thumbwheel_i = 8'h12;
    digital_in_i = 2'h0;
    critical_error_i = 1'b0;
    adc_code_i = 16'h0000;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    w(10);
    chk(supply_indicator_o, 1'b1);
    chk(map_addr_valid_o, 1'b1);
    t_regs();
    t_inputs();
    t_fault();
    t_leds();
    t_wheel();
    summarize();
  end
endmodule

// file: tb/iefs_host.sv
// host-side model: register master plus link and mode lines
`timescale 1ns/10ps
module iefs_host (
  input  wire logic                clk_i,
  input  wire iefs_pkg::iefs_rsp_t rsp_i,
  output iefs_pkg::iefs_req_t      req_o,
  output logic                     link_up_o,
  output logic                     register_mode_o,
  output logic                     config_mode_o,
  output logic                     partner_ok_o
);
  import iefs_pkg::*;
  // idle host: link present, i/o data mode, partner found
  initial begin
    req_o = '0;
    link_up_o = 1'b1;
    register_mode_o = 1'b0;
    config_mode_o = 1'b0;
    partner_ok_o = 1'b1;
  end
  // one word per strobe, released fields inverted so stale values never help
  task automatic wr(input logic [15:0] a, input logic [7:0] f, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{a, d, f, 1'b1, 1'b0};
    @(posedge clk_i);
    req_o <= '{~a, ~d, ~f, 1'b0, 1'b0};
  endtask
  // answer stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] f, output iefs_rsp_t r);
    @(posedge clk_i);
    req_o <= '{a, 16'h0, f, 1'b0, 1'b1};
    @(posedge clk_i);
    req_o <= '{~a, 16'hffff, ~f, 1'b0, 1'b0};
    @(negedge clk_i);
    r = rsp_i;
  endtask
endmodule
